// [rtl/charger_ctl_pkg.sv]
// Types for the charger mode and fault control block.
// Assumes the constants header is compiled alongside.
`default_nettype none
package charger_ctl_pkg;
  typedef enum logic [1:0] {MODE_CHARGE, MODE_CONFIG, MODE_BOOST, MODE_HIZ} op_mode_t;
  typedef enum logic [2:0] {BST_OFF, BST_LIN, BST_SS, BST_RUN, BST_WAIT} boost_state_t;

  // Analogue comparator results.
  typedef struct packed {
    logic bat_above_bus;     // Battery above bus voltage.
    logic mid_near_bat;      // Mid rail within 400 mV of battery.
    logic bus_in_window;     // Bus within 5% of setpoint.
    logic bus_above_95;      // Bus at or above 95% of setpoint.
    logic bus_above_target;  // Bus above the boost target.
    logic bat_above_uvlo;    // Battery above boost undervoltage threshold.
    logic min_off_done;      // Minimum off-time has ended.
  } sense_t;

  // Commands to the power stage.
  typedef struct packed {
    logic charge_en;         // Charger allowed to switch.
    logic hiz;               // Power stage high impedance.
    logic lin_source_en;     // 450 mA mid rail source.
    logic switch_en;         // Boost switching allowed.
    logic half_ilim;         // 50% peak current limit.
    logic loop_closed;       // Regulation loop closed.
    logic pulse_skip;        // Pulse-skip operation active.
    logic long_on_time;      // Longer minimum on-time.
  } power_t;

  typedef struct packed {
    logic [2:0]   fault_code;
    logic         boost_fault;
    logic [5:0]   control;
    logic [1:0]   pincfg;
    logic [7:0]   limits;
    logic         fallback;
    logic         disable_q;
    logic [35:0]  wdog_cnt;
    logic [35:0]  fb_cnt;
    logic [12:0]  stat_cnt;
    boost_state_t boost_run_state;
    logic [17:0]  bst_cnt;
    logic         retried;
    logic         skip;
    logic [31:0]  prdata;
  } state_t;
endpackage : charger_ctl_pkg
`default_nettype wire

// [rtl/charger_ctl_regs.svh]
// Constants for the charger mode and fault control block.
// Assumes a 40 MHz core clock on pclk and APB register access.
`ifndef CHARGER_CTL_REGS_SVH
`define CHARGER_CTL_REGS_SVH

`define CLK_HZ          40000000
// Register byte addresses.
`define ADDR_STATUS     12'h000
`define ADDR_CONTROL    12'h004
`define ADDR_LIMITS     12'h008
`define ADDR_PINCFG     12'h00c
// Control register fields.
`define CTL_OPSEL       0
`define CTL_HZREQ       1
`define CTL_INHIBIT     2
`define CTL_STATEN      3
`define CTL_RESET       4
`define CTL_KICK        5
`define CTL_RST_VAL     6'h08
// Pin configuration fields.
`define PIN_BOOSTEN     0
`define PIN_POLARITY    1
`define PIN_RST_VAL     2'h2
`define LIMITS_RST_VAL  8'h00
// Fault codes.
`define FLT_NONE        3'h0
`define FLT_VBUS_OVP    3'h1
`define FLT_SLEEP       3'h2
`define FLT_POOR_SRC    3'h3
`define FLT_BAT_OVP     3'h4
`define FLT_THERMAL     3'h5
`define FLT_TIMER       3'h6
`define FLT_NO_BAT      3'h7
// Boost fault codes.
`define BFLT_SOFTSTART  3'h2
`define BFLT_UVLO       3'h3
// Times in their own units.
`define STAT_PULSE_US   128
`define LIN_LIMIT_US    560
`define SS_FIRST_US     128
`define SS_SECOND_US    384
`define RETRY_FIRST_US  5200
`define RETRY_NEXT_US   5000
`define WDOG_S          32
`define FALLBACK_MIN    15
// Derived cycle counts.
`define CYC_US(t)       ((t) * (`CLK_HZ / 1000000))
`define STAT_PULSE_CYC  `CYC_US(`STAT_PULSE_US)
`define LIN_LIMIT_CYC   `CYC_US(`LIN_LIMIT_US)
`define SS_FIRST_CYC    `CYC_US(`SS_FIRST_US)
`define SS_SECOND_CYC   `CYC_US(`SS_SECOND_US)
`define RETRY_FIRST_CYC `CYC_US(`RETRY_FIRST_US)
`define RETRY_NEXT_CYC  `CYC_US(`RETRY_NEXT_US)
`define WDOG_CYC        (64'(`WDOG_S) * 64'(`CLK_HZ))
`define FALLBACK_CYC    (64'(`FALLBACK_MIN) * 64'd60 * 64'(`CLK_HZ))

`endif

// [rtl/charger_mode_fault_control.sv]
// Mode selection, fault reporting, timers and boost start-up sequencing.
// Assumes synchronous pins, a 40 MHz pclk and an APB master.
//
// How it works
// - Status pin low while charging if enabled.
// - Boost faults, and charge faults arising from no fault, pulse status pin 128 us.
// - Three-bit charge fault code reported.
// - High-impedance or inhibit bit stops charging.
// - Watchdog expiry resets registers except limits.
// - Fallback expiry sets inhibit; write or watchdog expiry restarts.
// - Reset bit restores defaults except limits.
// - Charge only when pin and bits clear.
// - Disable pin halts watchdog, resets fallback.
// - Mode from high-impedance, fault, operation select.
// - Operation select cleared when boost stops.
// - Boost pin polarity chosen by polarity bit.
// - Pin boost overrides high-impedance request.
// - High-impedance request overrides operation select.
// - Watchdog expiry in boost: reset, code 110.
// - Status read clears latched boost fault.
// - Bus above target after minimum off-time enters pulse-skip.
// - Boost sequences linear, soft-start, run.
// - Linear start-up fault after 560 us.
// - Soft-start half limit until bus in window or 128 us.
// - Full limit at 128 us, fault after 384.
// - Boost fault pulses, clears select, high impedance.
// - Pin boost retries after 5.2 ms, every 5.
`include "charger_ctl_regs.svh"
`default_nettype none

module charger_mode_fault_control #(
  parameter logic [35:0] WDOG_CYCLES     = 36'(`WDOG_CYC),     // Watchdog period.
  parameter logic [35:0] FALLBACK_CYCLES = 36'(`FALLBACK_CYC), // Fallback period.
  parameter logic [17:0] RETRY_FIRST     = 18'(`RETRY_FIRST_CYC), // First retry delay.
  parameter logic [17:0] RETRY_NEXT      = 18'(`RETRY_NEXT_CYC)   // Later retry delay.
) (
  input  wire logic                    pclk,             // Core clock.
  input  wire logic                    presetn,          // Asynchronous reset, low.
  input  wire logic                    psel,             // APB select.
  input  wire logic                    penable,          // APB enable.
  input  wire logic                    pwrite,           // APB write.
  input  wire logic [11:0]             paddr,            // APB byte address.
  input  wire logic [31:0]             pwdata,           // APB write data.
  output logic                         pready,           // APB ready.
  output logic [31:0]                  prdata,           // APB read data.
  output logic                         pslverr,          // APB error.
  input  wire logic                    charge_disable,   // Charge disable pin.
  input  wire logic                    boost_request_pin, // Boost request pin.
  input  wire logic [2:0]              charge_fault_in,  // Charge fault from monitors.
  input  wire logic                    boost_ovp,        // Bus over-voltage in boost.
  input  wire logic                    thermal_shutdown, // Die over temperature.
  input  wire charger_ctl_pkg::sense_t sense,            // Analogue comparators.
  output charger_ctl_pkg::power_t      power,            // Power stage commands.
  output charger_ctl_pkg::op_mode_t    mode,             // Operating mode.
  output logic                         stat_o,           // Status pin drive value.
  output logic                         stat_oe           // Status pin drive enable.
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  charger_ctl_pkg::state_t st_reg;
  charger_ctl_pkg::state_t st_next;

  logic       acc;
  logic       wr;
  logic       rd;
  logic       mapped;
  logic       pin_active;
  logic       boost_en;
  logic       boost_fault_ev;
  logic [2:0] boost_code;
  logic       wdog_exp;
  logic       fb_exp;
  logic       charge_ok;
  logic       any_fault;

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
    is_addr = (a == ref_a);
  endfunction : is_addr

  ////////////////////////////////////////////////////////////////////////////
  // Combinational terms.
  always_comb begin
    acc    = psel && penable;
    wr     = acc && pwrite;
    rd     = acc && !pwrite;
    mapped = is_addr(paddr, `ADDR_STATUS) || is_addr(paddr, `ADDR_CONTROL) ||
             is_addr(paddr, `ADDR_LIMITS) || is_addr(paddr, `ADDR_PINCFG);
    pin_active = (boost_request_pin == st_reg.pincfg[`PIN_POLARITY]);
    // Pin request wins over high impedance; high impedance masks select.
    // Boost is refused while fallback charging runs, since only 32-second mode allows it.
    boost_en = !st_reg.fallback &&
               ((st_reg.pincfg[`PIN_BOOSTEN] && pin_active) ||
                (!st_reg.control[`CTL_HZREQ] && st_reg.control[`CTL_OPSEL]));
    wdog_exp = (st_reg.wdog_cnt >= WDOG_CYCLES - 36'h1) && !st_reg.disable_q;
    fb_exp   = st_reg.fallback && (st_reg.fb_cnt >= FALLBACK_CYCLES - 36'h1);
    charge_ok = !charge_disable && !st_reg.control[`CTL_INHIBIT] &&
                !st_reg.control[`CTL_HZREQ];
    any_fault = (charge_fault_in != `FLT_NONE);
    boost_fault_ev = 1'b0;
    boost_code = `FLT_NONE;
    if (st_reg.boost_run_state != charger_ctl_pkg::BST_OFF && st_reg.boost_run_state != charger_ctl_pkg::BST_WAIT) begin
      if (thermal_shutdown) begin
        boost_fault_ev = 1'b1;
        boost_code = `FLT_THERMAL;
      end else if (boost_ovp) begin
        boost_fault_ev = 1'b1;
        boost_code = `FLT_VBUS_OVP;
      end else if (!sense.bat_above_uvlo) begin
        boost_fault_ev = 1'b1;
        boost_code = `BFLT_UVLO;
      end else if (st_reg.boost_run_state == charger_ctl_pkg::BST_LIN &&
                   st_reg.bst_cnt >= 18'(`LIN_LIMIT_CYC) - 18'h1) begin
        boost_fault_ev = 1'b1;
        boost_code = `BFLT_SOFTSTART;
      end else if (st_reg.boost_run_state == charger_ctl_pkg::BST_SS && !sense.bus_above_95 &&
                   st_reg.bst_cnt >= 18'(`SS_FIRST_CYC + `SS_SECOND_CYC) - 18'h1) begin
        boost_fault_ev = 1'b1;
        boost_code = `BFLT_SOFTSTART;
      end
    end
    if (st_reg.control[`CTL_HZREQ] && !boost_en) begin
      mode = charger_ctl_pkg::MODE_HIZ;
    end else if (boost_en || st_reg.boost_run_state != charger_ctl_pkg::BST_OFF) begin
      mode = charger_ctl_pkg::MODE_BOOST;
    end else if (any_fault) begin
      mode = charger_ctl_pkg::MODE_CONFIG;
    end else begin
      mode = charger_ctl_pkg::MODE_CHARGE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    st_next = st_reg;
    st_next.disable_q = charge_disable;
    if (st_reg.stat_cnt != 13'h0) begin
      st_next.stat_cnt = st_reg.stat_cnt - 13'h1;
    end
    // Watchdog halts while the disable pin is high.
    if (!charge_disable) begin
      st_next.wdog_cnt = st_reg.wdog_cnt + 36'h1;
    end
    if (st_reg.fallback) begin
      st_next.fb_cnt = charge_disable ? 36'h0 : st_reg.fb_cnt + 36'h1;
    end
    // Charge fault code and pulse on a new fault.
    if (st_reg.boost_run_state == charger_ctl_pkg::BST_OFF && !st_reg.boost_fault) begin
      st_next.fault_code = charge_fault_in;
      if (any_fault && st_reg.fault_code == `FLT_NONE) begin
        st_next.stat_cnt = 13'(`STAT_PULSE_CYC);
      end
    end
    // Register writes.
    if (wr && is_addr(paddr, `ADDR_CONTROL)) begin
      st_next.control = pwdata[5:0];
      if (pwdata[`CTL_KICK]) begin
        st_next.wdog_cnt = 36'h0;
      end
      st_next.control[`CTL_KICK] = 1'b0;
      st_next.fallback = 1'b0;
      if (pwdata[`CTL_RESET]) begin
        st_next.control = `CTL_RST_VAL;
        st_next.pincfg = `PIN_RST_VAL;
      end
    end
    if (wr && is_addr(paddr, `ADDR_PINCFG)) begin
      st_next.pincfg = pwdata[1:0];
    end
    if (wr && is_addr(paddr, `ADDR_LIMITS)) begin
      st_next.limits = pwdata[7:0];
    end
    // Reading the status register clears a latched boost fault.
    if (rd && is_addr(paddr, `ADDR_STATUS) && st_reg.boost_fault) begin
      st_next.boost_fault = 1'b0;
      st_next.fault_code = `FLT_NONE;
    end
    // Fallback expiry inhibits charging.
    if (fb_exp) begin
      st_next.control[`CTL_INHIBIT] = 1'b1;
      st_next.fallback = 1'b0;
      st_next.fb_cnt = 36'h0;
    end
    // Boost sequencer.
    st_next.bst_cnt = st_reg.bst_cnt + 18'h1;
    st_next.skip = 1'b0;
    case (st_reg.boost_run_state)
      charger_ctl_pkg::BST_OFF: begin
        st_next.bst_cnt = 18'h0;
        st_next.retried = 1'b0;
        if (boost_en) begin
          st_next.boost_run_state = charger_ctl_pkg::BST_LIN;
        end
      end
      charger_ctl_pkg::BST_LIN: begin
        if (sense.mid_near_bat && !sense.bat_above_bus) begin
          st_next.boost_run_state = charger_ctl_pkg::BST_SS;
          st_next.bst_cnt = 18'h0;
        end
      end
      charger_ctl_pkg::BST_SS: begin
        if (sense.bus_in_window && sense.bat_above_uvlo) begin
          st_next.boost_run_state = charger_ctl_pkg::BST_RUN;
        end
      end
      charger_ctl_pkg::BST_RUN: begin
        st_next.skip = st_reg.skip ? sense.bus_above_target
                     : (sense.min_off_done && sense.bus_above_target);
      end
      charger_ctl_pkg::BST_WAIT: begin
        if (!(st_reg.pincfg[`PIN_BOOSTEN] && pin_active)) begin
          st_next.boost_run_state = charger_ctl_pkg::BST_OFF;
        end else if (st_reg.bst_cnt >= (st_reg.retried ? RETRY_NEXT : RETRY_FIRST) - 18'h1) begin
          st_next.boost_run_state = charger_ctl_pkg::BST_LIN;
          st_next.bst_cnt = 18'h0;
          st_next.retried = 1'b1;
        end
      end
      default: begin
        st_next.boost_run_state = charger_ctl_pkg::BST_OFF;
      end
    endcase
    if (st_reg.boost_run_state != charger_ctl_pkg::BST_OFF && st_reg.boost_run_state != charger_ctl_pkg::BST_WAIT &&
        !boost_en && !boost_fault_ev) begin
      st_next.boost_run_state = charger_ctl_pkg::BST_OFF;
      st_next.control[`CTL_OPSEL] = 1'b0;
    end
    if (boost_fault_ev) begin
      st_next.boost_run_state = charger_ctl_pkg::BST_WAIT;
      st_next.bst_cnt = 18'h0;
      st_next.control[`CTL_OPSEL] = 1'b0;
      st_next.fault_code = boost_code;
      st_next.boost_fault = 1'b1;
      st_next.stat_cnt = 13'(`STAT_PULSE_CYC);
    end
    // Watchdog expiry resets the control and pin configuration registers but not the limits register.
    if (wdog_exp) begin
      st_next.control = `CTL_RST_VAL;
      st_next.pincfg = `PIN_RST_VAL;
      st_next.wdog_cnt = 36'h0;
      st_next.fb_cnt = 36'h0;
      st_next.fallback = 1'b1;
      if (st_reg.boost_run_state != charger_ctl_pkg::BST_OFF) begin
        st_next.boost_run_state = charger_ctl_pkg::BST_OFF;
        st_next.fault_code = `FLT_TIMER;
        st_next.boost_fault = 1'b1;
        st_next.stat_cnt = 13'(`STAT_PULSE_CYC);
      end
    end
    // Read data.
    st_next.prdata = 32'h0;
    if (is_addr(paddr, `ADDR_STATUS)) begin
      st_next.prdata = {25'h0, st_reg.boost_run_state, st_reg.boost_fault, st_reg.fault_code};
    end else if (is_addr(paddr, `ADDR_CONTROL)) begin
      st_next.prdata = {26'h0, st_reg.control};
    end else if (is_addr(paddr, `ADDR_LIMITS)) begin
      st_next.prdata = {24'h0, st_reg.limits};
    end else if (is_addr(paddr, `ADDR_PINCFG)) begin
      st_next.prdata = {30'h0, st_reg.pincfg};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{fault_code: `FLT_NONE, control: `CTL_RST_VAL, pincfg: `PIN_RST_VAL,
                  limits: `LIMITS_RST_VAL, fallback: 1'b1, boost_run_state: charger_ctl_pkg::BST_OFF,
                  default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = st_reg.prdata;
  // Fault pulse overrides the enable bit; charging pulls low only when enabled.
  assign stat_o  = 1'b0;
  assign stat_oe = (st_reg.stat_cnt != 13'h0) ||
                   (st_reg.control[`CTL_STATEN] && charge_ok &&
                    mode == charger_ctl_pkg::MODE_CHARGE);
  assign power.charge_en     = charge_ok && mode == charger_ctl_pkg::MODE_CHARGE;
  assign power.hiz           = mode == charger_ctl_pkg::MODE_HIZ ||
                               st_reg.boost_run_state == charger_ctl_pkg::BST_WAIT;
  assign power.lin_source_en = st_reg.boost_run_state == charger_ctl_pkg::BST_LIN;
  assign power.switch_en     = (st_reg.boost_run_state == charger_ctl_pkg::BST_SS ||
                                st_reg.boost_run_state == charger_ctl_pkg::BST_RUN) && !st_reg.skip;
  assign power.half_ilim     = st_reg.boost_run_state == charger_ctl_pkg::BST_SS &&
                               st_reg.bst_cnt < 18'(`SS_FIRST_CYC);
  assign power.loop_closed   = st_reg.boost_run_state == charger_ctl_pkg::BST_RUN;
  assign power.pulse_skip    = st_reg.skip;
  assign power.long_on_time  = st_reg.skip;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  AST_LIN_TIMEOUT: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.boost_run_state == charger_ctl_pkg::BST_LIN && st_reg.bst_cnt == 18'(`LIN_LIMIT_CYC) - 18'h1)
    |=> st_reg.boost_run_state != charger_ctl_pkg::BST_LIN)
    else $error("linear start-up exceeded its limit");
  AST_FAULT_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    boost_fault_ev |=> stat_oe [*8])
    else $error("status pulse missing after boost fault");
  AST_OPSEL_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    boost_fault_ev |=> !st_reg.control[`CTL_OPSEL])
    else $error("operation select not cleared");
  AST_HIZ_NO_CHARGE: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.control[`CTL_HZREQ] |-> !power.charge_en)
    else $error("charging with high impedance request");
  AST_WDOG_HALT: assert property (@(posedge pclk) disable iff (!presetn)
    (charge_disable && !wr) |=> st_reg.wdog_cnt == $past(st_reg.wdog_cnt))
    else $error("watchdog advanced while disabled");
  AST_WDOG_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    (wdog_exp && st_reg.boost_run_state != charger_ctl_pkg::BST_OFF) |=>
    st_reg.fault_code == `FLT_TIMER && st_reg.boost_run_state == charger_ctl_pkg::BST_OFF)
    else $error("watchdog boost fault not reported");
  AST_READ_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && is_addr(paddr, `ADDR_STATUS) && !boost_fault_ev && !wdog_exp) |=>
    !st_reg.boost_fault)
    else $error("status read did not clear boost fault");
  AST_FB_INHIBIT: assert property (@(posedge pclk) disable iff (!presetn)
    (fb_exp && !wdog_exp) |=> st_reg.control[`CTL_INHIBIT])
    else $error("fallback expiry did not inhibit");

endmodule : charger_mode_fault_control
`default_nettype wire

// [testbench/charger_mode_fault_control_tb_top.sv]
// Self-checking bench for the charger mode and fault control block.
// Assumes the host model drives APB; timers are shortened by parameters.
`include "charger_ctl_regs.svh"
`default_nettype none

module charger_mode_fault_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        charge_disable, boost_request_pin, boost_ovp, thermal_shutdown;
  logic        stat_o, stat_oe;
  logic [2:0]  charge_fault_in;
  charger_ctl_pkg::sense_t   sense;
  charger_ctl_pkg::power_t   power;
  charger_ctl_pkg::op_mode_t mode;
  int          miscompares, total_checks, n;

  charger_mode_fault_control #(.WDOG_CYCLES(36'd12000), .FALLBACK_CYCLES(36'd400),
    .RETRY_FIRST(18'd100), .RETRY_NEXT(18'd90)) charger_mode_fault_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .charge_disable(charge_disable), .boost_request_pin(boost_request_pin),
    .charge_fault_in(charge_fault_in), .boost_ovp(boost_ovp),
    .thermal_shutdown(thermal_shutdown), .sense(sense), .power(power), .mode(mode),
    .stat_o(stat_o), .stat_oe(stat_oe));
  host_model host_model_inst (.pclk(pclk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic print_verdict;
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc

  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic hung;
    host_model_inst.xfer(w, a, d, rdat, rerr, hung);
    if (hung) begin
      miscompares++;
      print_verdict();
    end
  endtask : acc

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    check(what, rdat & m, exp);
  endtask : rchk

  task automatic ctl(input logic [31:0] d);
    acc(1'b1, `ADDR_CONTROL, d);
    cyc(2);
  endtask : ctl

  task automatic mode_select;
    rchk("ctl_rst", `ADDR_CONTROL, 32'hff, 32'h08);
    rchk("pin_rst", `ADDR_PINCFG, 32'hff, 32'h02);
    rchk("lim_rst", `ADDR_LIMITS, 32'hff, 32'h00);
    acc(1'b0, 12'h010, 32'h0);
    check("unmapped", {rdat[30:0], rerr}, 32'h1);
    cyc(420);
    rchk("fallback_inhibit", `ADDR_CONTROL, 32'h04, 32'h04);
    check("inhibit_charge", 32'(power.charge_en), 32'h0);
    ctl(32'h28);
    check("charge_mode", 32'(mode), 32'(charger_ctl_pkg::MODE_CHARGE));
    check("charge_en", 32'(power.charge_en), 32'h1);
    check("stat_low", 32'(stat_oe), 32'h1);
    check("stat_drive", 32'(stat_o), 32'h0);
    ctl(32'h20);
    check("stat_open", 32'(stat_oe), 32'h0);
    ctl(32'h23);
    check("hiz_mode", 32'(mode), 32'(charger_ctl_pkg::MODE_HIZ));
    check("hiz_charge", 32'(power.charge_en), 32'h0);
    ctl(32'h24);
    check("inhibit_off", 32'(power.charge_en), 32'h0);
    acc(1'b1, `ADDR_CONTROL, 32'h20);
    charge_disable <= 1'b1;
    cyc(2);
    check("pin_disable", 32'(power.charge_en), 32'h0);
    charge_disable <= 1'b0;
    ctl(32'h21);
    check("boost_mode", 32'(mode), 32'(charger_ctl_pkg::MODE_BOOST));
    check("lin_source", 32'(power.lin_source_en), 32'h1);
    cyc(2);
    check("loop_closed", 32'(power.loop_closed), 32'h1);
    check("switching", 32'(power.switch_en), 32'h1);
    check("no_skip", 32'(power.pulse_skip), 32'h0);
    ctl(32'h23);
    rchk("opsel_clear", `ADDR_CONTROL, 32'h01, 32'h00);
  endtask : mode_select

  task automatic pin_boost;
    for (int p = 0; p < 2; p++) begin
      acc(1'b1, `ADDR_PINCFG, {30'h0, p[0], 1'b1});
      ctl(32'h22);
      boost_request_pin <= ~p[0];
      cyc(2);
      check("pin_idle", 32'(mode), 32'(charger_ctl_pkg::MODE_HIZ));
      boost_request_pin <= p[0];
      cyc(2);
      check("pin_boost", 32'(mode), 32'(charger_ctl_pkg::MODE_BOOST));
    end
    boost_request_pin <= 1'b0;
    acc(1'b1, `ADDR_PINCFG, 32'h2);
  endtask : pin_boost

  task automatic faults;
    ctl(32'h20);
    for (int c = 1; c < 8; c++) begin
      charge_fault_in <= 3'(c);
      cyc(2);
      check("config_mode", 32'(mode), 32'(charger_ctl_pkg::MODE_CONFIG));
      rchk("fault_code", `ADDR_STATUS, 32'h7, 32'(c));
    end
    charge_fault_in <= 3'h0;
    ctl(32'h20);
    n = 0;
    while (stat_oe !== 1'b0 && n < 6000) begin
      cyc(1);
      n++;
    end
    check("stat_release", 32'(stat_oe), 32'h0);
    charge_fault_in <= 3'h1;
    cyc(2);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (stat_oe === 1'b1 && n < 6000);
    check("pulse_len", 32'(n > 5100 && n < 5140), 32'h1);
    charge_fault_in <= 3'h0;
  endtask : faults

  task automatic watchdog;
    acc(1'b1, `ADDR_LIMITS, 32'h5a);
    ctl(32'h30);
    rchk("ctl_reset", `ADDR_CONTROL, 32'hff, 32'h08);
    rchk("lim_keep", `ADDR_LIMITS, 32'hff, 32'h5a);
    acc(1'b1, `ADDR_CONTROL, 32'h21);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (mode === charger_ctl_pkg::MODE_BOOST && n < 13000);
    check("wdog_len", 32'(n > 11900 && n < 12100), 32'h1);
    check("wdog_pulse", 32'(stat_oe), 32'h1);
    rchk("timer_code", `ADDR_STATUS, 32'hf, 32'he);
    rchk("wdog_ctl", `ADDR_CONTROL, 32'hff, 32'h08);
    rchk("wdog_lim", `ADDR_LIMITS, 32'hff, 32'h5a);
    rchk("fault_read_clr", `ADDR_STATUS, 32'h8, 32'h0);
  endtask : watchdog

  initial begin
    presetn = 1'b0;
    charge_disable = 1'b0;
    boost_request_pin = 1'b0;
    charge_fault_in = 3'h0;
    boost_ovp = 1'b0;
    thermal_shutdown = 1'b0;
    // Mid rail near battery, bus in window and above 95%, battery above threshold.
    sense = 7'h3a;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    mode_select();
    pin_boost();
    faults();
    watchdog();
    print_verdict();
  end
endmodule : charger_mode_fault_control_tb_top
`default_nettype wire

// [testbench/host_model.sv]
// Host processor model that reaches the block's registers over APB.
// Assumes one pclk domain; the slave may stall by holding pready low.
`default_nettype none

module host_model (
  input  wire logic        pclk,    // Core clock.
  input  wire logic        pready,  // Slave ready.
  input  wire logic [31:0] prdata,  // Read data.
  input  wire logic        pslverr, // Slave error.
  output var  logic        psel,    // Select.
  output var  logic        penable, // Enable.
  output var  logic        pwrite,  // Direction.
  output var  logic [11:0] paddr,   // Byte address.
  output var  logic [31:0] pwdata   // Write data.
);
  timeunit 1ns;
  timeprecision 1ps;

  initial {psel, penable, pwrite, paddr, pwdata} = '0;

  // The request is held until pready is seen high at a rising edge, or for at most 64 rising edges.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err, output logic hung);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    err = pslverr;
    hung = (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : host_model
`default_nettype wire
